//--- core/oscsw_pkg.sv
package oscsw_pkg;
    // Register byte addresses
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  ADDR_REQUEST    = 8'h00;
    localparam logic [7:0]  ADDR_ACTIVE     = 8'h04;
    localparam logic [7:0]  ADDR_SW_STATE   = 8'h08;
    localparam logic [7:0]  ADDR_OSC_STATUS = 8'h0C;
    localparam logic [7:0]  ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0]  ADDR_IRQ_ENABLE = 8'h14;
    localparam logic [7:0]  ADDR_IRQ_CLEAR  = 8'h18;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    // Source codes
    localparam logic [2:0]  SRC_EXT         = 3'h7;
    localparam logic [2:0]  SRC_FAST        = 3'h6;
    localparam logic [2:0]  SRC_SLOW        = 3'h5;
    localparam logic [2:0]  SRC_EXT_PLL4    = 3'h2;
    localparam logic [2:0]  SRC_FAST_PLL2   = 3'h1;
    // Divider codes, power of two ratio
    localparam logic [3:0]  DIV_MAX         = 4'h9;
    localparam logic [3:0]  DIV_FAST_RST    = 4'h2;
    localparam logic [3:0]  DIV_RST         = 4'h0;
    // Field positions
    localparam int          HOLD_BIT        = 7;
    localparam int          DONE_BIT        = 4;
    localparam int          NRDY_BIT        = 3;
    localparam int          EXT_RDY_BIT     = 7;
    localparam int          FAST_RDY_BIT    = 6;
    localparam int          MID_RDY_BIT     = 5;
    localparam int          SLOW_RDY_BIT    = 4;
    localparam int          CONV_RDY_BIT    = 2;
    localparam int          PLL_RDY_BIT     = 0;
    localparam int          IRQ_SW_BIT      = 0;
    // Quiet time around a clock change
    localparam int          MCLK_MHZ        = 200;
    localparam int          QUIET_NS        = 20;
    localparam int          QUIET_CYC       = (QUIET_NS * MCLK_MHZ + 999) / 1000;
    localparam logic [2:0]  QUIET_LAST      = 3'(QUIET_CYC - 1);

    typedef struct packed {
        logic [2:0] src;
        logic [3:0] div;
    } oscsw_sel_s;

    typedef struct packed {
        logic ext;
        logic fast;
        logic mid;
        logic slow;
        logic conv;
        logic pll_lock;
    } oscsw_rdy_s;

    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT, ST_HELD, ST_GATE, ST_SWAP, ST_UNGATE
    } oscsw_state_e;

    function automatic logic src_reserved(input logic [2:0] s);
        return !(s == SRC_EXT || s == SRC_FAST || s == SRC_SLOW
                 || s == SRC_EXT_PLL4 || s == SRC_FAST_PLL2);
    endfunction : src_reserved

    function automatic logic [3:0] rst_div(input logic [2:0] s);
        return (s == SRC_FAST) ? DIV_FAST_RST : DIV_RST;
    endfunction : rst_div
endpackage : oscsw_pkg

//--- core/oscsw_ctrl.sv
`timescale 1ns/10ps
module oscsw_ctrl
    import oscsw_pkg::*;
(
    // Clock, reset, enable
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    input  wire logic               clk_en,
    // Configuration fuses
    input  wire logic               switch_permit_fuse,
    input  wire logic [2:0]         reset_source_fuse,
    // Oscillator and PLL status
    input  wire oscsw_rdy_s         osc_rdy,
    // Clock selection towards the clock mux
    output oscsw_sel_s              active_sel_out,
    output oscsw_sel_s              request_sel_out,
    output logic                    sys_clk_gate,
    // Interrupt
    output logic                    irq,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0]  s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready
);
    oscsw_sel_s         req_reg;
    oscsw_sel_s         active_reg;
    oscsw_sel_s         target_reg;
    oscsw_state_e       st_reg;
    logic               init_pend_reg;
    logic               hold_reg;
    logic               nrdy_reg;
    logic               gate_reg;
    logic [2:0]         cnt_reg;
    logic               irq_sts_reg;
    logic               irq_en_reg;
    logic               irq_reg;
    logic [ADDR_W-1:0]  awaddr_reg;
    logic               aw_have_reg;
    logic [31:0]        wdata_reg;
    logic               wlane0_reg;
    logic               w_have_reg;
    logic               awready_reg;
    logic               wready_reg;
    logic               bvalid_reg;
    logic [1:0]         bresp_reg;
    logic               arready_reg;
    logic               rvalid_reg;
    logic [31:0]        rdata_reg;
    logic [1:0]         rresp_reg;
    logic               wr_fire;
    logic               wr_en;
    logic               wr_req;
    logic               wr_clr;
    logic               pending;
    logic               new_ok;
    logic               rdy_evt;
    logic               done;
    logic               pll_rdy;
    logic               pll_in_rdy;
    logic               pll_used;
    logic [2:0]         pll_src;
    logic [7:0]         rd_byte;
    logic               rd_hit;
    logic               wr_hit;

    assign active_sel_out  = active_reg;
    assign request_sel_out = req_reg;
    assign sys_clk_gate    = gate_reg;
    assign irq             = irq_reg;
    assign s_axi_awready   = awready_reg;
    assign s_axi_wready    = wready_reg;
    assign s_axi_bvalid    = bvalid_reg;
    assign s_axi_bresp     = bresp_reg;
    assign s_axi_arready   = arready_reg;
    assign s_axi_rvalid    = rvalid_reg;
    assign s_axi_rdata     = rdata_reg;
    assign s_axi_rresp     = rresp_reg;

    // Requested source readiness, PLL codes also need lock
    function automatic logic src_ready(input logic [2:0] s, input oscsw_rdy_s r);
        unique case (s)
            SRC_EXT:       return r.ext;
            SRC_FAST:      return r.fast;
            SRC_SLOW:      return r.slow;
            SRC_EXT_PLL4:  return r.ext && r.pll_lock;
            SRC_FAST_PLL2: return r.fast && r.pll_lock;
            default:       return 1'b0;
        endcase
    endfunction : src_ready

    assign pll_src    = (req_reg.src == SRC_EXT_PLL4 || req_reg.src == SRC_FAST_PLL2)
                        ? req_reg.src : active_reg.src;
    assign pll_used   = (pll_src == SRC_EXT_PLL4 || pll_src == SRC_FAST_PLL2);
    assign pll_in_rdy = (pll_src == SRC_EXT_PLL4) ? osc_rdy.ext : osc_rdy.fast;
    assign pll_rdy    = pll_used && pll_in_rdy && osc_rdy.pll_lock;

    assign pending = (req_reg != active_reg);
    assign new_ok  = src_ready(req_reg.src, osc_rdy);
    assign rdy_evt = !init_pend_reg && st_reg == ST_WAIT && pending && new_ok;
    assign done    = (st_reg == ST_IDLE) && !pending;

    // Write path decode; only byte lane 0 carries register bits
    assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
    assign wr_en   = wr_fire && wlane0_reg;
    assign wr_hit  = awaddr_reg == ADDR_REQUEST || awaddr_reg == ADDR_ACTIVE
                     || awaddr_reg == ADDR_SW_STATE || awaddr_reg == ADDR_OSC_STATUS
                     || awaddr_reg == ADDR_IRQ_STATUS || awaddr_reg == ADDR_IRQ_ENABLE
                     || awaddr_reg == ADDR_IRQ_CLEAR;
    assign wr_req  = wr_en && awaddr_reg == ADDR_REQUEST && switch_permit_fuse
                     && !init_pend_reg && !src_reserved(wdata_reg[6:4]);
    assign wr_clr  = wr_en && awaddr_reg == ADDR_IRQ_CLEAR && wdata_reg[IRQ_SW_BIT];

    // The reset source fuse is sampled one enabled cycle after reset release
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            init_pend_reg <= 1'b1;
        end else if (clk_en) begin
            init_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            req_reg <= '0;
        end else if (clk_en) begin
            if (init_pend_reg) begin
                req_reg <= '{src: reset_source_fuse, div: rst_div(reset_source_fuse)};
            end else if (wr_req) begin
                req_reg <= '{src: wdata_reg[6:4], div: wdata_reg[3:0]};
            end
        end
    end

    // software may clear hold to proceed
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_reg <= 1'b0;
        end else if (clk_en && wr_en && awaddr_reg == ADDR_SW_STATE) begin
            hold_reg <= wdata_reg[HOLD_BIT];
        end
    end

    // Switch sequencer; the clock is gated for a quiet span on each side of the swap
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg     <= ST_IDLE;
            active_reg <= '0;
            target_reg <= '0;
            nrdy_reg   <= 1'b0;
            gate_reg   <= 1'b1;
            cnt_reg    <= '0;
        end else if (clk_en) begin
            if (init_pend_reg) begin
                active_reg <= '{src: reset_source_fuse, div: rst_div(reset_source_fuse)};
            end else begin
                unique case (st_reg)
                    ST_IDLE: begin
                        if (pending) begin
                            st_reg <= ST_WAIT;
                        end
                    end
                    ST_WAIT: begin
                        if (!pending) begin
                            st_reg <= ST_IDLE;
                        end else if (new_ok) begin
                            nrdy_reg   <= 1'b1;
                            target_reg <= req_reg;
                            st_reg     <= hold_reg ? ST_HELD : ST_GATE;
                        end
                    end
                    ST_HELD: begin
                        if (!pending) begin
                            nrdy_reg <= 1'b0;
                            st_reg   <= ST_IDLE;
                        end else if (!new_ok) begin
                            nrdy_reg <= 1'b0;
                            st_reg   <= ST_WAIT;
                        end else if (!hold_reg) begin
                            target_reg <= req_reg;
                            st_reg     <= ST_GATE;
                        end
                    end
                    ST_GATE: begin
                        gate_reg <= 1'b0;
                        if (cnt_reg == QUIET_LAST) begin
                            cnt_reg <= '0;
                            st_reg  <= ST_SWAP;
                        end else begin
                            cnt_reg <= cnt_reg + 3'h1;
                        end
                    end
                    ST_SWAP: begin
                        active_reg <= target_reg;
                        nrdy_reg   <= 1'b0;
                        st_reg     <= ST_UNGATE;
                    end
                    ST_UNGATE: begin
                        if (cnt_reg == QUIET_LAST) begin
                            cnt_reg  <= '0;
                            gate_reg <= 1'b1;
                            st_reg   <= ST_IDLE;
                        end else begin
                            cnt_reg <= cnt_reg + 3'h1;
                        end
                    end
                endcase
            end
        end
    end

    // Interrupt flag; a ready event in the clear cycle still sets it
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_sts_reg <= 1'b0;
            irq_en_reg  <= 1'b0;
            irq_reg     <= 1'b0;
        end else if (clk_en) begin
            irq_sts_reg <= (irq_sts_reg && !wr_clr) || rdy_evt;
            if (wr_en && awaddr_reg == ADDR_IRQ_ENABLE) begin
                irq_en_reg <= wdata_reg[IRQ_SW_BIT];
            end
            irq_reg <= irq_sts_reg && irq_en_reg;
        end
    end

    // Write channels taken in either order, one response after both
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= '0;
            wlane0_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else if (clk_en) begin
            awready_reg <= !aw_have_reg && !bvalid_reg && !(s_axi_awvalid && awready_reg);
            wready_reg  <= !w_have_reg && !bvalid_reg && !(s_axi_wvalid && wready_reg);
            if (s_axi_awvalid && awready_reg) begin
                awaddr_reg  <= s_axi_awaddr;
                aw_have_reg <= 1'b1;
            end
            if (s_axi_wvalid && wready_reg) begin
                wdata_reg  <= s_axi_wdata;
                wlane0_reg <= s_axi_wstrb[0];
                w_have_reg <= 1'b1;
            end
            if (wr_fire) begin
                aw_have_reg <= 1'b0;
                w_have_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        unique case (s_axi_araddr)
            ADDR_REQUEST:    rd_byte = {1'b0, req_reg};
            ADDR_ACTIVE:     rd_byte = {1'b0, active_reg};
            ADDR_SW_STATE: begin
                rd_byte[HOLD_BIT] = hold_reg;
                rd_byte[DONE_BIT] = done;
                rd_byte[NRDY_BIT] = nrdy_reg;
            end
            ADDR_OSC_STATUS: begin
                rd_byte[EXT_RDY_BIT]  = osc_rdy.ext;
                rd_byte[FAST_RDY_BIT] = osc_rdy.fast;
                rd_byte[MID_RDY_BIT]  = osc_rdy.mid;
                rd_byte[SLOW_RDY_BIT] = osc_rdy.slow;
                rd_byte[CONV_RDY_BIT] = osc_rdy.conv;
                rd_byte[PLL_RDY_BIT]  = pll_rdy;
            end
            ADDR_IRQ_STATUS: rd_byte[IRQ_SW_BIT] = irq_sts_reg;
            ADDR_IRQ_ENABLE: rd_byte[IRQ_SW_BIT] = irq_en_reg;
            ADDR_IRQ_CLEAR:  rd_byte = 8'h00;
            default:         rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && arready_reg) begin
                arready_reg <= 1'b0;
                rvalid_reg  <= 1'b1;
                rdata_reg   <= {24'h000000, rd_byte};
                rresp_reg   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end else if (!rvalid_reg) begin
                arready_reg <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_quiet_span;
        !gate_reg [*8];
    endsequence

    sequence s_ready_hit;
        rdy_evt && clk_en;
    endsequence

    a_rsv_src_kept: assert property (
        (wr_en && clk_en && awaddr_reg == ADDR_REQUEST && src_reserved(wdata_reg[6:4]))
        |=> req_reg == $past(req_reg))
        else $error("reserved source write changed request");
    a_fuse_lock: assert property (
        (!switch_permit_fuse && !init_pend_reg) |=> $stable(req_reg))
        else $error("request changed with permit fuse low");
    a_reset_div: assert property (
        (init_pend_reg && clk_en) |=> req_reg.div ==
        (($past(reset_source_fuse) == SRC_FAST) ? DIV_FAST_RST : DIV_RST))
        else $error("reset divider wrong");
    a_active_init: assert property (
        (init_pend_reg && clk_en) |=> active_reg == req_reg)
        else $error("active not equal to request after reset");
    a_hold_stays: assert property (
        (st_reg == ST_HELD && hold_reg && pending && new_ok && clk_en)
        |=> st_reg == ST_HELD && active_reg == $past(active_reg))
        else $error("held switch proceeded");
    a_nrdy_busy: assert property (
        nrdy_reg |-> st_reg != ST_IDLE && st_reg != ST_WAIT)
        else $error("new-ready set outside a switch");
    a_swap_done: assert property (
        (st_reg == ST_SWAP && clk_en) |=> active_reg == $past(target_reg) && !nrdy_reg)
        else $error("swap did not update active or clear new-ready");
    a_irq_set: assert property (
        s_ready_hit |=> irq_sts_reg && nrdy_reg)
        else $error("ready event lost");
    a_gate_quiet: assert property (
        ($changed(active_reg) && !init_pend_reg && !$past(init_pend_reg)) |-> !gate_reg)
        else $error("active changed with clock running");
    a_gate_span: assert property (
        $fell(gate_reg) |-> s_quiet_span)
        else $error("clock gate reopened early");
    a_rsvd_zero: assert property (
        rvalid_reg |-> rdata_reg[31:8] == 24'h000000)
        else $error("reserved read bits nonzero");
endmodule : oscsw_ctrl

//--- tb/oscsw_osc_model.sv
`timescale 1ns/10ps
// Oscillators and PLL: a newly requested source needs a start-up time
module oscsw_osc_model
    import oscsw_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // Selections and knobs
    input  wire oscsw_sel_s req,
    input  wire oscsw_sel_s act,
    input  wire logic       slow,
    input  wire logic       mid_on,
    input  wire logic       conv_on,
    // Ready levels
    output oscsw_rdy_s      rdy
);
    logic [4:0] cnt_reg;
    logic [2:0] last_reg;
    logic       up;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg  <= 5'h00;
            last_reg <= 3'h0;
        end else begin
            last_reg <= req.src;
            cnt_reg  <= (req.src != last_reg) ? 5'h00 : cnt_reg + {4'h0, cnt_reg != 5'h1F};
        end
    end
    // Slow start-up leaves the switch visibly waiting
    assign up       = (req.src == last_reg) && cnt_reg >= (slow ? 5'h14 : 5'h02);
    // The source in use stays ready, a new one after its start-up
    assign rdy.ext  = act.src inside {SRC_EXT, SRC_EXT_PLL4} || (req.src inside {SRC_EXT, SRC_EXT_PLL4} && up);
    assign rdy.fast = act.src inside {SRC_FAST, SRC_FAST_PLL2} || (req.src inside {SRC_FAST, SRC_FAST_PLL2} && up);
    assign rdy.slow = act.src == SRC_SLOW || (req.src == SRC_SLOW && up);
    assign rdy.mid  = mid_on;
    assign rdy.conv = conv_on;
    assign rdy.pll_lock = act.src inside {SRC_EXT_PLL4, SRC_FAST_PLL2} || (req.src inside {SRC_EXT_PLL4, SRC_FAST_PLL2} && up);
endmodule : oscsw_osc_model

//--- tb/oscillator_select_switch_control_bench.sv
`timescale 1ns/10ps
module oscillator_select_switch_control_bench
    import oscsw_pkg::*;
;
    logic mclk, sys_clk_gate, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, sys_rst = 1'b1, clk_en = 1'b1, switch_permit_fuse = 1'b1;
    logic slow = 1'b0, mid_on = 1'b1, conv_on = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [2:0] reset_source_fuse = SRC_FAST;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    oscsw_rdy_s osc_rdy;
    oscsw_sel_s active_sel_out, request_sel_out;
    int n_fail = 0, n_tests = 0;
    oscsw_ctrl dut_u (.mclk, .sys_rst, .clk_en, .switch_permit_fuse, .reset_source_fuse,
        .osc_rdy, .active_sel_out, .request_sel_out, .sys_clk_gate, .irq, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    oscsw_osc_model osc_u (.mclk, .sys_rst, .req(request_sel_out), .act(active_sel_out), .slow,
        .mid_on, .conv_on, .rdy(osc_rdy));
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task automatic tout;
        n_fail++;
        $display("mismatch at %0t: wait ran out", $time);
        close_out();
    endtask : tout
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 100);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 100) tout();
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        int n = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 100);
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 100) tout();
    endtask : axi_rd
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        axi_rd(a);
        chk(rdv, {24'h0, e});
    endtask : rchk
    // Bounded polling: a switch that never finishes must end the run
    task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
        int n = 0;
        do begin
            axi_rd(a);
            n++;
        end while ((rdv[7:0] & m) !== v && n < 200);
        if (n >= 200) tout();
    endtask : poll
    task automatic t_reset;
        rchk(ADDR_REQUEST, 8'h62);
        rchk(ADDR_ACTIVE, 8'h62);
        rchk(ADDR_SW_STATE, 8'h10);
        rchk(ADDR_IRQ_STATUS, 8'h00);
    endtask : t_reset
    task automatic t_bus;
        axi_wr(8'h1C, 8'hFF);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        axi_wr(ADDR_SW_STATE, 8'h7F);
        rchk(ADDR_SW_STATE, 8'h10);
        axi_wr(ADDR_ACTIVE, 8'h00);
        rchk(ADDR_ACTIVE, 8'h62);
        s_axi_wstrb <= 4'hE;
        axi_wr(ADDR_IRQ_ENABLE, 8'h01);
        s_axi_wstrb <= 4'hF;
        rchk(ADDR_IRQ_ENABLE, 8'h00);
    endtask : t_bus
    task automatic t_protect;
        logic [2:0] bad [3] = '{3'h4, 3'h3, 3'h0};
        for (int i = 0; i < 3; i++) begin
            axi_wr(ADDR_REQUEST, {1'b0, bad[i], 4'h3});
            rchk(ADDR_REQUEST, 8'h62);
        end
        @(posedge mclk);
        switch_permit_fuse <= 1'b0;
        axi_wr(ADDR_REQUEST, 8'h70);
        rchk(ADDR_REQUEST, 8'h62);
        switch_permit_fuse <= 1'b1;
    endtask : t_protect
    task automatic t_switch;
        oscsw_sel_s tbl [5] = '{'{SRC_EXT, DIV_MAX}, '{SRC_FAST, 4'h0}, '{SRC_FAST_PLL2, 4'h1},
                                '{SRC_SLOW, 4'h5}, '{SRC_EXT_PLL4, 4'h0}};
        for (int i = 0; i < 5; i++) begin
            axi_wr(ADDR_REQUEST, {1'b0, tbl[i]});
            poll(ADDR_SW_STATE, 8'h10, 8'h10);
            rchk(ADDR_ACTIVE, {1'b0, tbl[i]});
            chk({25'h0, active_sel_out}, {25'h0, tbl[i]});
        end
        rchk(ADDR_OSC_STATUS, 8'hA5);
        mid_on <= 1'b0;
        conv_on <= 1'b0;
        rchk(ADDR_OSC_STATUS, 8'h81);
    endtask : t_switch
    task automatic t_hold;
        slow <= 1'b1;
        axi_wr(ADDR_SW_STATE, 8'h80);
        axi_wr(ADDR_REQUEST, 8'h59);
        rchk(ADDR_SW_STATE, 8'h80);
        poll(ADDR_SW_STATE, 8'h08, 8'h08);
        repeat (10) @(posedge mclk);
        rchk(ADDR_SW_STATE, 8'h88);
        rchk(ADDR_ACTIVE, 8'h20);
        // Software releases the held switch
        axi_wr(ADDR_SW_STATE, 8'h00);
        poll(ADDR_SW_STATE, 8'h10, 8'h10);
        rchk(ADDR_ACTIVE, 8'h59);
        rchk(ADDR_SW_STATE, 8'h10);
        // Held switch abandoned by copying the active setting back
        axi_wr(ADDR_SW_STATE, 8'h80);
        axi_wr(ADDR_REQUEST, 8'h79);
        poll(ADDR_SW_STATE, 8'h08, 8'h08);
        axi_wr(ADDR_REQUEST, 8'h59);
        rchk(ADDR_SW_STATE, 8'h90);
        rchk(ADDR_ACTIVE, 8'h59);
        axi_wr(ADDR_SW_STATE, 8'h00);
        slow <= 1'b0;
    endtask : t_hold
    task automatic t_irq;
        chk({31'h0, irq}, 32'h0);
        rchk(ADDR_IRQ_STATUS, 8'h01);
        axi_wr(ADDR_IRQ_ENABLE, 8'h01);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, 32'h1);
        axi_wr(ADDR_IRQ_CLEAR, 8'h01);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        axi_wr(ADDR_REQUEST, 8'h52);
        poll(ADDR_SW_STATE, 8'h10, 8'h10);
        chk({31'h0, irq}, 32'h1);
        axi_wr(ADDR_IRQ_ENABLE, 8'h00);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
    endtask : t_irq
    // Second reset with a non-fast fuse source, divider resets to 0000
    task automatic t_rst2;
        @(posedge mclk);
        reset_source_fuse <= SRC_EXT;
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        rchk(ADDR_REQUEST, 8'h70);
        rchk(ADDR_ACTIVE, 8'h70);
        rchk(ADDR_SW_STATE, 8'h10);
    endtask : t_rst2
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset();
        t_bus();
        t_protect();
        t_switch();
        t_hold();
        t_irq();
        t_rst2();
        close_out();
    end
endmodule : oscillator_select_switch_control_bench
